// ### irqidx_defs.svh
// Offsets, field positions and reset values of the converter enable and interrupt index registers
`ifndef IRQIDX_DEFS_SVH
`define IRQIDX_DEFS_SVH

// ==========================================================
// Register offsets within a page
`define IRQIDX_GLOBAL_SPAN 8'h10
`define IRQIDX_CONV_EN_OFS 8'h05
`define IRQIDX_HOST_IDX_OFS 8'h06
`define IRQIDX_MCU_IDX_OFS 8'h0A
`define IRQIDX_IDX_BYTES 8'h04
`define IRQIDX_ROUTE_OFS 8'h10
`define IRQIDX_ROUTE_PAGE 2'h0

// ==========================================================
// Reset values
`define IRQIDX_CONV_EN_RST 8'h00
`define IRQIDX_ROUTE_RST 32'hFFFF_77FF
`define IRQIDX_RDATA_RST 8'h00

// ==========================================================
// Field positions
`define IRQIDX_BIT_SMALL_BUCK_A 0
`define IRQIDX_BIT_SMALL_BUCK_B 1
`define IRQIDX_BIT_LARGE_BUCK 2
`define IRQIDX_BIT_SYS_BOOST 3
`define IRQIDX_BIT_BACKLIGHT 4
`define IRQIDX_BIT_SPEAKER 7
`define IRQIDX_BIT_BOTH 15
`define IRQIDX_SPK_FAULT_BIT 4
`define IRQIDX_CONV_FAULT_MSB 3

`endif

// ### irqidx_pkg.sv
// Types shared by the interrupt index and converter enable block
`default_nettype none
package irqidx_pkg;

  typedef logic [31:0] irqidx_map_t;

  typedef enum logic [2:0] {
    IRQIDX_SEL_NONE = 3'b000,
    IRQIDX_SEL_CONV = 3'b001,
    IRQIDX_SEL_HOST = 3'b010,
    IRQIDX_SEL_MCU = 3'b011,
    IRQIDX_SEL_ROUTE = 3'b100
  } irqidx_sel_e;

endpackage

`default_nettype wire

// ### irqidx_top.sv
// Converter enable register, routing mask and host / microcontroller interrupt index views
// ==========================================================
// Behaviour
// - Enable bits switch power stages, reset off
// - Host index is 32-bit read-only, resets zero
// - Microcontroller index follows, read-only, resets zero
// - Index mirrors module flags, holds no state
// - Shared map: pins, switches, reserved bits
// - Both flag acts only in routing
// - Byte 2 timers, alarms, charger sources
// - Regulator fault is OR of eight bits
// - Converter fault is OR of bits 3..0
// - Speaker fault needs bit 4 in both
// - Byte 3 touch, supply, ADC, temperature sources
// - Byte 3 bit 1 is die temperature high
// - Routing mask: 1 internal, 0 external, reset FFFF77FF
// - First 16 offsets global across pages
`timescale 1ns/1ps
`default_nettype none
`include "irqidx_defs.svh"

module irqidx_top
  import irqidx_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_B,
  // Byte register port
  input wire logic [1:0] REG_PAGE,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // Pin and switch flags
  input wire logic [9:0] GPIO_PEND,
  input wire logic SHORT_PRESS_SWITCH,
  input wire logic MID_PRESS_SWITCH,
  // Timer, alarm and charger flags
  input wire logic WATCHDOG_PEND,
  input wire logic GENERAL_TIMER_PEND,
  input wire logic CLOCK_ALARM_FIRST,
  input wire logic CLOCK_ALARM_SECOND,
  input wire logic CHARGER_PEND,
  // Fault status registers of other modules
  input wire logic [7:0] REGULATOR_FAULT_FLAGS,
  input wire logic [7:0] CONVERTER_FAULT_FLAGS,
  input wire logic [7:0] SPK_STATUS_A,
  input wire logic [7:0] SPK_STATUS_B,
  // Touch and ADC flags
  input wire logic PEN_DOWN_PEND,
  input wire logic DIE_TEMP_HIGH,
  input wire logic BATTERY_LOW,
  input wire logic VSYS_LOW,
  input wire logic ADC_OTHER_PEND,
  input wire logic BATTERY_XLOW,
  input wire logic DIE_TEMP_XHIGH,
  // Power stage enables
  output logic SMALL_BUCK_A_ON,
  output logic SMALL_BUCK_B_ON,
  output logic LARGE_BUCK_ON,
  output logic SYSTEM_BOOST_ON,
  output logic BACKLIGHT_BOOST_ON,
  output logic SPEAKER_STAGE_ON
);

  // ==========================================================
  // Address decode
  // Page ignored below the global span; routing mask lives on page 0 only
  // Pages 1-3 at the routing offsets answer nothing here
  function automatic irqidx_sel_e decode(input logic [1:0] page, input logic [7:0] addr);
    irqidx_sel_e sel;
    sel = IRQIDX_SEL_NONE;
    if (addr < `IRQIDX_GLOBAL_SPAN) begin
      if (addr == `IRQIDX_CONV_EN_OFS) begin
        sel = IRQIDX_SEL_CONV;
      end else if (addr >= `IRQIDX_HOST_IDX_OFS && addr < `IRQIDX_MCU_IDX_OFS) begin
        sel = IRQIDX_SEL_HOST;
      end else if (addr >= `IRQIDX_MCU_IDX_OFS && addr < (`IRQIDX_MCU_IDX_OFS + `IRQIDX_IDX_BYTES)) begin
        sel = IRQIDX_SEL_MCU;
      end
    end else if (page == `IRQIDX_ROUTE_PAGE && addr >= `IRQIDX_ROUTE_OFS &&
                 addr < (`IRQIDX_ROUTE_OFS + `IRQIDX_IDX_BYTES)) begin
      sel = IRQIDX_SEL_ROUTE;
    end
    return sel;
  endfunction

  // Picks byte n of a word, lowest address holding byte 0
  function automatic logic [7:0] pick_byte(input irqidx_map_t word, input logic [1:0] n);
    return word[{n, 3'b000} +: 8];
  endfunction

  // Byte number inside a four-byte word, counted from its base offset
  function automatic logic [1:0] index_byte(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] ofs;
    ofs = addr - base;
    return ofs[1:0];
  endfunction

  // Routes the shared map to one side; the both flag opens both
  function automatic irqidx_map_t route_view(input irqidx_map_t src, input irqidx_map_t msk, input logic to_mcu);
    irqidx_map_t allow;
    allow = to_mcu ? msk : ~msk;
    allow = allow | {32{msk[`IRQIDX_BIT_BOTH]}};
    allow[`IRQIDX_BIT_BOTH] = 1'b0;
    return src & allow;
  endfunction

  // ==========================================================
  // Source map, purely combinational
  irqidx_map_t src_map;
  irqidx_map_t host_view;
  irqidx_map_t mcu_view;
  irqidx_map_t route_reg;
  irqidx_map_t route_next;
  logic [7:0] conv_en_reg;
  logic [7:0] conv_en_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  irqidx_sel_e acc_sel;
  logic [1:0] byte_n;

  // No flops here: clearing happens in the owning module
  always_comb begin
    // Reserved positions 0, 11, 13, 15 and 31 keep the zero default
    src_map = '0;
    src_map[7:1] = GPIO_PEND[6:0];
    src_map[10:8] = GPIO_PEND[9:7];
    src_map[12] = SHORT_PRESS_SWITCH;
    src_map[14] = MID_PRESS_SWITCH;
    src_map[16] = WATCHDOG_PEND;
    src_map[17] = GENERAL_TIMER_PEND;
    src_map[18] = CLOCK_ALARM_FIRST;
    src_map[19] = CLOCK_ALARM_SECOND;
    src_map[20] = |REGULATOR_FAULT_FLAGS;
    src_map[21] = |CONVERTER_FAULT_FLAGS[`IRQIDX_CONV_FAULT_MSB:0];
    src_map[22] = CHARGER_PEND;
    src_map[23] = SPK_STATUS_A[`IRQIDX_SPK_FAULT_BIT] & SPK_STATUS_B[`IRQIDX_SPK_FAULT_BIT];
    src_map[24] = PEN_DOWN_PEND;
    src_map[25] = DIE_TEMP_HIGH;
    src_map[26] = BATTERY_LOW;
    src_map[27] = VSYS_LOW;
    src_map[28] = ADC_OTHER_PEND;
    src_map[29] = BATTERY_XLOW;
    src_map[30] = DIE_TEMP_XHIGH;
  end

  // ==========================================================
  // Routing split into the two views
  // Views are live: a four-byte read may straddle a flag change
  always_comb begin
    host_view = route_view(src_map, route_reg, 1'b0);
    mcu_view = route_view(src_map, route_reg, 1'b1);
  end

  // ==========================================================
  // Register next values
  always_comb begin
    acc_sel = decode(REG_PAGE, REG_ADDR);
    conv_en_next = conv_en_reg;
    route_next = route_reg;
    rdata_next = rdata_reg;
    byte_n = 2'b00;
    case (acc_sel)
      IRQIDX_SEL_HOST: byte_n = index_byte(REG_ADDR, `IRQIDX_HOST_IDX_OFS);
      IRQIDX_SEL_MCU: byte_n = index_byte(REG_ADDR, `IRQIDX_MCU_IDX_OFS);
      IRQIDX_SEL_ROUTE: byte_n = index_byte(REG_ADDR, `IRQIDX_ROUTE_OFS);
      default: byte_n = 2'b00;
    endcase
    // Index views take no write at all; mask takes byte writes
    if (REG_WR) begin
      case (acc_sel)
        IRQIDX_SEL_CONV: conv_en_next = REG_WDATA;
        IRQIDX_SEL_ROUTE: route_next[{byte_n, 3'b000} +: 8] = REG_WDATA;
        default: route_next = route_reg;
      endcase
    end
    // Read and write in one cycle: the read returns the old value
    if (REG_RD) begin
      case (acc_sel)
        IRQIDX_SEL_CONV: rdata_next = conv_en_reg;
        IRQIDX_SEL_HOST: rdata_next = pick_byte(host_view, byte_n);
        IRQIDX_SEL_MCU: rdata_next = pick_byte(mcu_view, byte_n);
        IRQIDX_SEL_ROUTE: rdata_next = pick_byte(route_reg, byte_n);
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Synchronous reset; first access allowed at the first edge after release
  // Reserved enable bits 6:5 are stored so software reads what it wrote
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      conv_en_reg <= `IRQIDX_CONV_EN_RST;
      route_reg <= `IRQIDX_ROUTE_RST;
      rdata_reg <= `IRQIDX_RDATA_RST;
    end else begin
      conv_en_reg <= conv_en_next;
      route_reg <= route_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // Outputs
  // Enables come straight from the register flops, no decode glitch
  always_comb begin
    REG_RDATA = rdata_reg;
    SMALL_BUCK_A_ON = conv_en_reg[`IRQIDX_BIT_SMALL_BUCK_A];
    SMALL_BUCK_B_ON = conv_en_reg[`IRQIDX_BIT_SMALL_BUCK_B];
    LARGE_BUCK_ON = conv_en_reg[`IRQIDX_BIT_LARGE_BUCK];
    SYSTEM_BOOST_ON = conv_en_reg[`IRQIDX_BIT_SYS_BOOST];
    BACKLIGHT_BOOST_ON = conv_en_reg[`IRQIDX_BIT_BACKLIGHT];
    SPEAKER_STAGE_ON = conv_en_reg[`IRQIDX_BIT_SPEAKER];
  end

endmodule

`default_nettype wire

// ### irqidx_props.sv
// Checker for the enable register and the index read port
`timescale 1ns/1ps
`default_nettype none
module irqidx_props (
  // Clock, reset and register port
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  // Stage enables
  input wire logic SMALL_BUCK_A_ON,
  input wire logic SMALL_BUCK_B_ON,
  input wire logic LARGE_BUCK_ON,
  input wire logic SYSTEM_BOOST_ON,
  input wire logic BACKLIGHT_BOOST_ON,
  input wire logic SPEAKER_STAGE_ON
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  wire [5:0] en = {SPEAKER_STAGE_ON, BACKLIGHT_BOOST_ON, SYSTEM_BOOST_ON,
                   LARGE_BUCK_ON, SMALL_BUCK_B_ON, SMALL_BUCK_A_ON};
  wire [5:0] wen = {REG_WDATA[7], REG_WDATA[4:0]};
  wire w5 = REG_WR && REG_ADDR == 8'h05;
  // Read with a write in the same cycle left out: old or new data is open
  wire rd5 = REG_RD && REG_ADDR == 8'h05 && !REG_WR;
  // ==========================================================
  // Assertions
  chk_conv_write: assert property (w5 |=> en == $past(wen)) else $error("enable write lost");
  chk_conv_hold: assert property (!w5 |=> $stable(en)) else $error("enable moved");
  chk_conv_read: assert property (rd5 |=> {REG_RDATA[7], REG_RDATA[4:0]} == $past(en))
    else $error("enable read");
  chk_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA)) else $error("read data moved");
  chk_unmapped_zero: assert property (REG_RD && REG_ADDR > 8'h13 |=> REG_RDATA == 8'h00)
    else $error("unmapped");
  chk_rsvd_byte0: assert property (REG_RD && REG_ADDR inside {8'h06, 8'h0A} |=> !REG_RDATA[0])
    else $error("b0");
  chk_rsvd_byte1: assert property (REG_RD && REG_ADDR inside {8'h07, 8'h0B} |=> (REG_RDATA & 8'hA8) == 8'h00)
    else $error("b1");
  chk_rsvd_byte3: assert property (REG_RD && REG_ADDR inside {8'h09, 8'h0D} |=> !REG_RDATA[7])
    else $error("b3");
  cover property (w5);
  cover property (REG_RD && REG_ADDR == 8'h0C);
  cover property (rd5);
  cover property (REG_RD && REG_ADDR == 8'h08);
endmodule
bind irqidx_top irqidx_props props (
  .SYS_CLK(SYS_CLK),
  .RST_B(RST_B),
  .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA),
  .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA),
  .SMALL_BUCK_A_ON(SMALL_BUCK_A_ON),
  .SMALL_BUCK_B_ON(SMALL_BUCK_B_ON),
  .LARGE_BUCK_ON(LARGE_BUCK_ON),
  .SYSTEM_BOOST_ON(SYSTEM_BOOST_ON),
  .BACKLIGHT_BOOST_ON(BACKLIGHT_BOOST_ON),
  .SPEAKER_STAGE_ON(SPEAKER_STAGE_ON)
);
`default_nettype wire

// ### irqidx_host.sv
// Host model driving the byte register port
`timescale 1ns/1ps
`default_nettype none
module irqidx_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [1:0] pg,
  output logic [7:0] ad,
  output logic wr,
  output logic [7:0] wd,
  output logic rd,
  input wire logic [7:0] rdat
);
  initial {pg, ad, wr, wd, rd} = '0;
  // Released address and data lines show the inverse so a stale value cannot pass
  task automatic acc(input logic w, input logic [1:0] p, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    {pg, ad, wd, wr, rd} = {p, a, d, w, !w};
    @(negedge clk);
    {ad, wd, wr, rd} = {~a, ~d, 2'b00};
    q = rdat;
  endtask
endmodule
`default_nettype wire

// ### irqidx_top_tb.sv
// Self-checking bench for the enable and interrupt index block
`timescale 1ns/1ps
`default_nettype none
module irqidx_top_tb;
  logic clk = 0;
  logic rst_b = 0;
  logic [55:0] f = '0;
  logic [31:0] mask = 32'hFFFF_77FF;
  logic [31:0] w;
  logic [7:0] q, d, ad, wd, rdat;
  logic [1:0] pg;
  logic wr, rd;
  wire [5:0] on;
  int fails = 0, checks_done = 0, cyc = 0;
  always #50 clk = ~clk;
  irqidx_host host (.clk(clk), .pg(pg), .ad(ad), .wr(wr), .wd(wd), .rd(rd), .rdat(rdat));
  irqidx_top uut (.SYS_CLK(clk), .RST_B(rst_b), .REG_PAGE(pg), .REG_ADDR(ad), .REG_WR(wr), .REG_WDATA(wd), .REG_RD(rd),
    .REG_RDATA(rdat), .GPIO_PEND(f[9:0]), .SHORT_PRESS_SWITCH(f[10]), .MID_PRESS_SWITCH(f[11]), .WATCHDOG_PEND(f[12]),
    .GENERAL_TIMER_PEND(f[13]), .CLOCK_ALARM_FIRST(f[14]), .CLOCK_ALARM_SECOND(f[15]), .CHARGER_PEND(f[16]),
    .REGULATOR_FAULT_FLAGS(f[24:17]), .CONVERTER_FAULT_FLAGS(f[32:25]), .SPK_STATUS_A(f[40:33]),
    .SPK_STATUS_B(f[48:41]), .PEN_DOWN_PEND(f[49]), .DIE_TEMP_HIGH(f[50]), .BATTERY_LOW(f[51]), .VSYS_LOW(f[52]),
    .ADC_OTHER_PEND(f[53]), .BATTERY_XLOW(f[54]), .DIE_TEMP_XHIGH(f[55]), .SMALL_BUCK_A_ON(on[0]),
    .SMALL_BUCK_B_ON(on[1]), .LARGE_BUCK_ON(on[2]), .SYSTEM_BOOST_ON(on[3]), .BACKLIGHT_BOOST_ON(on[4]),
    .SPEAKER_STAGE_ON(on[5]));
  // ==========================================================
  // Expected views
  function automatic logic [31:0] view(input logic host_side);
    logic [31:0] m;
    m = {1'b0, f[55:49], f[37] & f[45], f[16], |f[28:25], |f[24:17], f[15:12],
         1'b0, f[11], 1'b0, f[10], 1'b0, f[9:7], f[6:0], 1'b0};
    return m & ((host_side ? ~mask : mask) | {32{mask[15]}});
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rdw(input logic [1:0] p, input logic [7:0] b);
    for (int i = 0; i < 4; i++) begin
      host.acc(1'b0, p, b + 8'(i), 8'h00, q);
      w[8*i+:8] = q;
    end
  endtask
  task automatic test_done;
    $display("counts fails=%0d checks=%0d", fails, checks_done);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Ceiling well above the roughly 1050 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(32'h7fa3));
    repeat (2) @(posedge clk);
    @(negedge clk) rst_b = 1;
    rdw(2'h0, 8'h10); chk(w, 32'hFFFF_77FF);
    rdw(2'h3, 8'h06); chk(w, 32'h0);
    rdw(2'h1, 8'h0A); chk(w, 32'h0);
    chk(on, 6'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'h81 : 8'($urandom);
      host.acc(1'b1, 2'($urandom), 8'h05, d, q);
      chk(on, {d[7], d[4:0]});
      host.acc(1'b1, 2'h0, 8'h06 + 8'(i), ~d, q);
      chk(on, {d[7], d[4:0]});
      host.acc(1'b0, 2'($urandom), 8'h05, 8'h00, q);
      chk(q, d);
    end
    $display("test enable done");
    for (int i = 0; i < 40; i++) begin
      mask = (i == 0) ? 32'h0000_8000 : (i == 1) ? 32'h0 : $urandom;
      for (int b = 0; b < 4; b++) host.acc(1'b1, 2'h0, 8'h10 + 8'(b), mask[8*b+:8], q);
      f = (i < 2) ? '1 : 56'({$urandom, $urandom});
      rdw(2'($urandom), 8'h06); chk(w, view(1'b1));
      rdw(2'($urandom), 8'h0A); chk(w, view(1'b0));
    end
    $display("test views done");
    // Mid-run reset drops every stage and restores the routing mask
    host.acc(1'b1, 2'h0, 8'h05, 8'hFF, q);
    chk(on, 6'h3F);
    @(negedge clk) rst_b = 0;
    repeat (2) @(posedge clk);
    @(negedge clk) rst_b = 1;
    chk(on, 6'h00);
    host.acc(1'b1, 2'h1, 8'h10, 8'h00, q);
    rdw(2'h0, 8'h10);
    chk(w, 32'hFFFF_77FF);
    host.acc(1'b0, 2'h2, 8'h05, 8'h00, q);
    chk(q, 8'h00);
    $display("test midreset done");
    host.acc(1'b0, 2'h0, 8'h40, 8'h00, q); chk(q, 8'h00);
    $display("test unmapped done");
    test_done();
  end
endmodule
`default_nettype wire
